// ### verilog/cmf_ctrl.sv
// Local design decisions: the address map and the plain strobed port.
module cmf_ctrl (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Protocol engine side
  input  wire logic        rx_msg_done,
  input  wire logic        rx_error,
  input  wire logic        mode_ack,
  input  wire logic [4:0]  depth_in,
  input  wire logic        depth_wr,
  // Outputs to the engine, filter and timer
  output logic      [2:0]  current_mode_status,
  output logic      [2:0]  requested_mode,
  output logic             timer_capture,
  output logic             register_window_select,
  output logic      [16:0] payload_compare_mask,
  output logic             payload_compare_on,
  output logic             depth_invalid,
  output logic             copy_partial,
  output logic             bus_pins_active
);
  logic [2:0]  req_r, req_nxt;
  logic [2:0]  stat_r, stat_nxt;
  logic        cap_en_r, cap_en_nxt;
  logic        win_r, win_nxt;
  logic [4:0]  depth_r, depth_nxt;
  logic [1:0]  wait_r, wait_nxt;
  logic        cap_r, cap_nxt;
  logic        part_r, part_nxt;
  logic [15:0] rdata_r, rdata_nxt;

  function automatic logic legal_mode(input logic [2:0] m);
    return !(m == cmf_pkg::MODE_RES5 || m == cmf_pkg::MODE_RES6);
  endfunction

  // Write decode shared by the update logic and the checks below
  function automatic logic ctrl1_write(input logic wr, input logic [3:0] addr);
    return wr && addr == cmf_pkg::ADDR_CTRL1;
  endfunction

  // Status follows the request once the engine agrees or after a short wait
  always_comb begin
    req_nxt    = req_r;
    cap_en_nxt = cap_en_r;
    win_nxt    = win_r;
    stat_nxt   = stat_r;
    wait_nxt   = wait_r;
    depth_nxt  = depth_wr ? depth_in : depth_r;
    if (ctrl1_write(reg_wr, reg_addr)) begin
      // Reserved codes are dropped so status can never show them
      if (legal_mode(reg_wdata[cmf_pkg::REQ_LSB +: 3])) begin // [RULE6]
        req_nxt  = reg_wdata[cmf_pkg::REQ_LSB +: 3];
        wait_nxt = 2'(cmf_pkg::MODE_WAIT);
      end
      cap_en_nxt = reg_wdata[cmf_pkg::CAP_BIT];
      win_nxt    = reg_wdata[cmf_pkg::WIN_BIT]; // [RULE8]
    end else if (stat_r != req_r) begin
      if (mode_ack || wait_r == 2'h0) begin
        stat_nxt = req_r; // [RULE1] [RULE2]
      end else begin
        wait_nxt = wait_r - 2'h1;
      end
    end
  end

  always_comb begin
    cap_nxt  = cap_en_r && rx_msg_done; // [RULE3]
    part_nxt = (stat_r == cmf_pkg::MODE_RXALL) && rx_error; // [RULE7]
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        cmf_pkg::ADDR_CTRL1: begin
          rdata_nxt[cmf_pkg::REQ_LSB +: 3]  = req_r;
          rdata_nxt[cmf_pkg::STAT_LSB +: 3] = stat_r; // [RULE1]
          rdata_nxt[cmf_pkg::CAP_BIT]       = cap_en_r;
          rdata_nxt[cmf_pkg::WIN_BIT]       = win_r;
        end
        cmf_pkg::ADDR_CTRL2: rdata_nxt[4:0] = depth_r;
        default:             rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_r    <= cmf_pkg::REQ_RESET;
      stat_r   <= cmf_pkg::STAT_RESET;
      cap_en_r <= 1'b0;
      win_r    <= 1'b0;
      depth_r  <= cmf_pkg::DEPTH_RESET;
      wait_r   <= 2'h0;
      cap_r    <= 1'b0;
      part_r   <= 1'b0;
      rdata_r  <= 16'h0000;
    end else begin
      req_r    <= req_nxt;
      stat_r   <= stat_nxt;
      cap_en_r <= cap_en_nxt;
      win_r    <= win_nxt;
      depth_r  <= depth_nxt;
      wait_r   <= wait_nxt;
      cap_r    <= cap_nxt;
      part_r   <= part_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  cmf_depth_mask u_mask (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .depth     (depth_r),
    .mask_r    (payload_compare_mask),
    .invalid_r (depth_invalid)
  );

  assign reg_rdata              = rdata_r;
  assign current_mode_status    = stat_r;
  assign requested_mode         = req_r;
  assign timer_capture          = cap_r;
  assign register_window_select = win_r;
  assign payload_compare_on     = |payload_compare_mask; // [RULE5]
  assign copy_partial           = part_r;
  assign bus_pins_active        = (stat_r == cmf_pkg::MODE_NORMAL); // [RULE6]

  property p_status_legal;
    @(posedge clk) disable iff (sys_rst) legal_mode(stat_r);
  endproperty
  a_status_legal: assert property (p_status_legal) else $error("reserved mode shown"); // [RULE2]

  property p_status_follows;
    @(posedge clk) disable iff (sys_rst)
      (stat_r != req_r && !reg_wr) ##1 !reg_wr [*3] |-> stat_r == $past(req_r, 3);
  endproperty
  a_status_follows: assert property (p_status_follows) else $error("status lags"); // [RULE1]

  property p_cap_on;
    @(posedge clk) disable iff (sys_rst) (cap_en_r && rx_msg_done) |=> timer_capture;
  endproperty
  a_cap_on: assert property (p_cap_on) else $error("capture missed"); // [RULE3]

  property p_cap_off;
    @(posedge clk) disable iff (sys_rst) timer_capture |-> $past(cap_en_r) && $past(rx_msg_done);
  endproperty
  a_cap_off: assert property (p_cap_off) else $error("spurious capture"); // [RULE3]

  property p_depth_zero;
    @(posedge clk) disable iff (sys_rst) depth_r == 5'h00 |=> payload_compare_mask == 17'h00000;
  endproperty
  a_depth_zero: assert property (p_depth_zero) else $error("depth 0 compares payload"); // [RULE5]

  property p_depth_top;
    @(posedge clk) disable iff (sys_rst)
      depth_r == cmf_pkg::DEPTH_MAX |=> payload_compare_mask == 17'h1FFFF;
  endproperty
  a_depth_top: assert property (p_depth_top) else $error("depth 17 mask wrong"); // [RULE4]

  property p_req_write;
    @(posedge clk) disable iff (sys_rst)
      (reg_wr && reg_addr == cmf_pkg::ADDR_CTRL1 && reg_wdata[10:8] == 3'h0)
      |=> requested_mode == 3'h0;
  endproperty
  a_req_write: assert property (p_req_write) else $error("normal request lost"); // [RULE6]

  property p_partial;
    @(posedge clk) disable iff (sys_rst)
      (stat_r == cmf_pkg::MODE_RXALL && rx_error) |=> copy_partial;
  endproperty
  a_partial: assert property (p_partial) else $error("partial copy missed"); // [RULE7]

  property p_win;
    @(posedge clk) disable iff (sys_rst)
      ctrl1_write(reg_wr, reg_addr)
      |=> register_window_select == $past(reg_wdata[cmf_pkg::WIN_BIT]);
  endproperty
  a_win: assert property (p_win) else $error("window select not stored"); // [RULE8]

  // Status may only ever step onto the pending request, never elsewhere
  property p_stat_jump;
    @(posedge clk) disable iff (sys_rst)
      !$stable(stat_r) |-> stat_r == $past(req_r);
  endproperty
  a_stat_jump: assert property (p_stat_jump) else $error("status took odd code"); // [RULE1]

  property p_stat_hold;
    @(posedge clk) disable iff (sys_rst)
      stat_r == req_r |=> $stable(stat_r);
  endproperty
  a_stat_hold: assert property (p_stat_hold) else $error("settled status moved"); // [RULE1]

  property p_stat_defer;
    @(posedge clk) disable iff (sys_rst)
      ctrl1_write(reg_wr, reg_addr) |=> $stable(stat_r);
  endproperty
  a_stat_defer: assert property (p_stat_defer) else $error("write did not defer"); // [RULE1]

  property p_req_drop;
    @(posedge clk) disable iff (sys_rst)
      ctrl1_write(reg_wr, reg_addr) && !legal_mode(reg_wdata[cmf_pkg::REQ_LSB +: 3])
      |=> $stable(requested_mode);
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("reserved request kept"); // [RULE2]

  property p_req_take;
    @(posedge clk) disable iff (sys_rst)
      ctrl1_write(reg_wr, reg_addr) && legal_mode(reg_wdata[cmf_pkg::REQ_LSB +: 3])
      |=> requested_mode == $past(reg_wdata[cmf_pkg::REQ_LSB +: 3]);
  endproperty
  a_req_take: assert property (p_req_take) else $error("request not stored"); // [RULE6]

  property p_req_hold;
    @(posedge clk) disable iff (sys_rst)
      !ctrl1_write(reg_wr, reg_addr) |=> $stable(requested_mode);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request moved"); // [RULE6]

  property p_req_legal;
    @(posedge clk) disable iff (sys_rst)
      legal_mode(req_r);
  endproperty
  a_req_legal: assert property (p_req_legal) else $error("reserved request held"); // [RULE2]

  property p_cap_store;
    @(posedge clk) disable iff (sys_rst)
      ctrl1_write(reg_wr, reg_addr) |=> cap_en_r == $past(reg_wdata[cmf_pkg::CAP_BIT]);
  endproperty
  a_cap_store: assert property (p_cap_store) else $error("capture enable lost"); // [RULE3]

  property p_cap_hold;
    @(posedge clk) disable iff (sys_rst)
      !ctrl1_write(reg_wr, reg_addr) |=> $stable(cap_en_r);
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capture enable moved"); // [RULE3]

  property p_cap_dis;
    @(posedge clk) disable iff (sys_rst)
      !cap_en_r |=> !timer_capture;
  endproperty
  a_cap_dis: assert property (p_cap_dis) else $error("capture while disabled"); // [RULE3]

  property p_cap_idle;
    @(posedge clk) disable iff (sys_rst)
      !rx_msg_done |=> !timer_capture;
  endproperty
  a_cap_idle: assert property (p_cap_idle) else $error("capture without message"); // [RULE3]

  property p_win_hold;
    @(posedge clk) disable iff (sys_rst)
      !ctrl1_write(reg_wr, reg_addr) |=> $stable(register_window_select);
  endproperty
  a_win_hold: assert property (p_win_hold) else $error("window moved"); // [RULE8]

  // Mask length is checked against the depth code, not against the mask module
  property p_mask_val;
    @(posedge clk) disable iff (sys_rst)
      depth_r <= cmf_pkg::DEPTH_MAX
      |=> payload_compare_mask == 17'((18'h00001 << $past(depth_r)) - 18'h00001);
  endproperty
  a_mask_val: assert property (p_mask_val) else $error("mask length wrong"); // [RULE4]

  property p_mask_bad;
    @(posedge clk) disable iff (sys_rst)
      depth_r > cmf_pkg::DEPTH_MAX |=> depth_invalid && payload_compare_mask == 17'h00000;
  endproperty
  a_mask_bad: assert property (p_mask_bad) else $error("invalid depth compared"); // [RULE4]

  property p_mask_ok;
    @(posedge clk) disable iff (sys_rst)
      depth_r <= cmf_pkg::DEPTH_MAX |=> !depth_invalid;
  endproperty
  a_mask_ok: assert property (p_mask_ok) else $error("valid depth flagged"); // [RULE4]

  property p_cmp_on;
    @(posedge clk) disable iff (sys_rst)
      payload_compare_on |-> payload_compare_mask[0];
  endproperty
  a_cmp_on: assert property (p_cmp_on) else $error("mask not from bit 0"); // [RULE5]

  property p_part_idle;
    @(posedge clk) disable iff (sys_rst)
      !(stat_r == cmf_pkg::MODE_RXALL && rx_error) |=> !copy_partial;
  endproperty
  a_part_idle: assert property (p_part_idle) else $error("copy outside receive-all"); // [RULE7]

  property p_part_mode;
    @(posedge clk) disable iff (sys_rst)
      copy_partial |-> $past(stat_r) == cmf_pkg::MODE_RXALL;
  endproperty
  a_part_mode: assert property (p_part_mode) else $error("copy in wrong mode"); // [RULE7]

  property p_rd_stat;
    @(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == cmf_pkg::ADDR_CTRL1
      |=> reg_rdata[cmf_pkg::STAT_LSB +: 3] == $past(stat_r);
  endproperty
  a_rd_stat: assert property (p_rd_stat) else $error("status readback wrong"); // [RULE1]

  property p_rd_req;
    @(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == cmf_pkg::ADDR_CTRL1
      |=> reg_rdata[cmf_pkg::REQ_LSB +: 3] == $past(req_r);
  endproperty
  a_rd_req: assert property (p_rd_req) else $error("request readback wrong"); // [RULE6]

  property p_rd_depth;
    @(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == cmf_pkg::ADDR_CTRL2 |=> reg_rdata[4:0] == $past(depth_r);
  endproperty
  a_rd_depth: assert property (p_rd_depth) else $error("depth readback wrong"); // [RULE4]
endmodule

// ### verilog/cmf_pkg.sv
// Contract
// (RULE1) Read-only three-bit mode status: 000 normal, 001 disabled, 010 loopback.
// (RULE2) Status 011 listen-only, 100 configuration, 111 receive-all; 101/110 never reported.
// (RULE3) Capture enable set: one timer capture pulse per received message; clear: none.
// (RULE4) Compare depth 1..17 extends ID filter into payload bits; above 17 invalid.
// (RULE5) Compare depth zero: filter uses identifier only, no payload bits.
// (RULE6) Writable three-bit mode request, same codes; 000 selects normal bus operation.
// (RULE7) Receive-all mode ignores errors and copies partial frame to receive buffer.
// (RULE8) Window-select bit: 1 shows filter registers, 0 shows buffer registers.
package cmf_pkg;
  localparam logic [3:0] ADDR_CTRL1   = 4'h0;
  localparam logic [3:0] ADDR_CTRL2   = 4'h1;
  localparam int         REQ_LSB      = 8;
  localparam int         STAT_LSB     = 5;
  localparam int         CAP_BIT      = 3;
  localparam int         WIN_BIT      = 0;
  localparam logic [2:0] REQ_RESET    = 3'h4;
  localparam logic [2:0] STAT_RESET   = 3'h4;
  localparam logic [4:0] DEPTH_RESET  = 5'h00;
  localparam logic [4:0] DEPTH_MAX    = 5'h11;
  localparam int         DEPTH_MAX_I  = 17;
  localparam int         MODE_WAIT    = 2;

  typedef enum logic [2:0] {
    MODE_NORMAL  = 3'b000,
    MODE_DISABLE = 3'b001,
    MODE_LOOP    = 3'b010,
    MODE_LISTEN  = 3'b011,
    MODE_CONFIG  = 3'b100,
    MODE_RES5    = 3'b101,
    MODE_RES6    = 3'b110,
    MODE_RXALL   = 3'b111
  } cmf_mode_type;
endpackage

// ### verilog/cmf_depth_mask.sv
// Turns a compare depth into a mask of payload bits to compare
module cmf_depth_mask (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Depth in, mask out
  input  wire logic [4:0]  depth,
  output logic      [16:0] mask_r,
  output logic             invalid_r
);
  logic [16:0] mask_nxt;
  logic        invalid_nxt;

  always_comb begin
    mask_nxt    = 17'h00000;
    invalid_nxt = depth > cmf_pkg::DEPTH_MAX;
    for (int i = 0; i < cmf_pkg::DEPTH_MAX_I; i++) begin
      // Bit i pairs identifier bit i with payload bit i counted from byte 1 bit 7
      if (!invalid_nxt && (i < int'(depth))) begin // [RULE4] [RULE5]
        mask_nxt[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_r    <= 17'h00000;
      invalid_r <= 1'b0;
    end else begin
      mask_r    <= mask_nxt;
      invalid_r <= invalid_nxt;
    end
  end
endmodule

// ### test/cmf_engine_model.sv
// Protocol engine stand-in: accepts each new mode request after a delay
module cmf_engine_model #(
  parameter int ACK_DLY = 1
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Mode handshake
  input  wire logic [2:0] requested_mode,
  output logic            mode_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] seen_r;
  int         cnt;
  always @(posedge clk) begin
    if (sys_rst) begin
      mode_ack <= 1'b0;
      seen_r   <= cmf_pkg::REQ_RESET;
      cnt      <= 0;
    end else if (requested_mode !== seen_r && cnt == ACK_DLY) begin
      // Acknowledge once per request; only with ACK_DLY above 1 is this slower than the design's own wait
      mode_ack <= 1'b1;
      seen_r   <= requested_mode;
      cnt      <= 0;
    end else begin
      mode_ack <= 1'b0;
      if (requested_mode !== seen_r) cnt <= cnt + 1;
    end
  end
endmodule

// ### test/cmf_ctrl_tb.sv
module cmf_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, reg_wr, reg_rd, rx_msg_done, rx_error, mode_ack, depth_wr;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_val;
  logic [4:0] depth_in;
  logic [2:0] current_mode_status, requested_mode;
  logic [16:0] payload_compare_mask;
  logic timer_capture, register_window_select, payload_compare_on, depth_invalid;
  logic copy_partial, bus_pins_active;
  int err_total, comparisons, i;
  cmf_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_msg_done(rx_msg_done),
    .rx_error(rx_error), .mode_ack(mode_ack), .depth_in(depth_in), .depth_wr(depth_wr),
    .current_mode_status(current_mode_status), .requested_mode(requested_mode),
    .timer_capture(timer_capture), .register_window_select(register_window_select),
    .payload_compare_mask(payload_compare_mask), .payload_compare_on(payload_compare_on),
    .depth_invalid(depth_invalid), .copy_partial(copy_partial),
    .bus_pins_active(bus_pins_active));
  cmf_engine_model #(.ACK_DLY(3)) engine (.clk(clk), .sys_rst(sys_rst),
    .requested_mode(requested_mode), .mode_ack(mode_ack));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic stop_test();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string name, logic [16:0] exp, logic [16:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic wait_mode(logic [2:0] m);
    for (i = 0; i < 12 && current_mode_status !== m; i++) begin
      @(posedge clk);
      #1;
    end
    if (current_mode_status !== m) begin
      $display("MISMATCH mode wait expected %h seen %h", m, current_mode_status);
      err_total++;
      stop_test();
    end
  endtask
  task automatic t_reset();
    rd(4'h0); chk("ctrl_one", 17'h00480, {1'b0, rd_val});
    rd(4'h1); chk("ctrl_two", 17'h0, {1'b0, rd_val});
    rd(4'hF); chk("unmapped", 17'h0, {1'b0, rd_val});
  endtask
  task automatic t_modes();
    logic [2:0] codes[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4};
    foreach (codes[k]) begin
      wr(4'h0, {5'h0, codes[k], 8'h00});
      wait_mode(codes[k]);
      rd(4'h0); chk("mode", {6'h0, codes[k], codes[k], 5'h0}, {1'b0, rd_val});
      chk("pins", 17'(codes[k] == 3'h0), 17'(bus_pins_active));
      chk("req port", 17'(codes[k]), 17'(requested_mode));
    end
  endtask
  task automatic t_reserved_capture();
    wr(4'h0, 16'h0509);
    repeat (6) @(posedge clk);
    rd(4'h0); chk("reserved", 17'h00489, {1'b0, rd_val});
    chk("window", 17'h1, 17'(register_window_select));
    for (int c = 1; c >= 0; c--) begin
      wr(4'h0, {5'h00, 3'h4, 4'h0, c[0], 3'h0});
      @(posedge clk) {rx_msg_done, rx_error} <= 2'h3;
      @(posedge clk) {rx_msg_done, rx_error} <= 2'h0;
      #1 chk("capture", 17'(c), 17'(timer_capture));
      chk("no copy", 17'h0, 17'(copy_partial));
      @(posedge clk) #1 chk("capture end", 17'h0, 17'(timer_capture));
    end
    chk("window off", 17'h0, 17'(register_window_select));
  endtask
  task automatic t_depth();
    logic [4:0] d[4] = '{5'h00, 5'h01, 5'h11, 5'h12};
    logic [16:0] exp_mask;
    foreach (d[k]) begin
      exp_mask = (d[k] > 5'h11) ? 17'h00000 : 17'((18'h00001 << d[k]) - 18'h00001);
      @(posedge clk) begin depth_in <= d[k]; depth_wr <= 1'b1; end
      @(posedge clk) depth_wr <= 1'b0;
      @(posedge clk);
      #1 chk("mask", exp_mask, payload_compare_mask);
      chk("on", 17'(d[k] inside {[5'h01 : 5'h11]}), 17'(payload_compare_on));
      chk("invalid", 17'(d[k] > 5'h11), 17'(depth_invalid));
      rd(4'h1); chk("depth rd", 17'(d[k]), {1'b0, rd_val});
    end
  endtask
  task automatic t_rxall();
    wr(4'h0, 16'h0700);
    wait_mode(3'h7);
    @(posedge clk) rx_error <= 1'b1;
    @(posedge clk) rx_error <= 1'b0;
    #1 chk("partial copy", 17'h1, 17'(copy_partial));
    @(posedge clk) #1 chk("partial end", 17'h0, 17'(copy_partial));
  endtask
  initial begin
    {sys_rst, reg_wr, reg_rd, rx_msg_done, rx_error, depth_wr} = 6'h20;
    {reg_addr, reg_wdata, depth_in} = '0;
    err_total = 0; comparisons = 0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_modes();
    t_reserved_capture();
    t_depth();
    t_rxall();
    stop_test();
  end
endmodule
